/* gdc_pkg.sv */
// Constants, field layout and carrier types for the gate driver control registers.
// Assumes a single 50 MHz clock; all timing counts below derive from its period.
`default_nettype none

package gdc_pkg;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int DATA_W = 11;    // Register data width
  localparam int ADDR_W = 4;     // Register address width
  localparam int FRAME_W = 16;   // Bits in one serial frame
  localparam int HDR_BITS = 5;   // Read flag plus address

  // ----------------------------------------------------------------
  // Register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_LS = 4'h6;     // low_side_drive_strength
  localparam logic [3:0] ADDR_GD = 4'h7;     // gate_drive_settings
  localparam logic [3:0] ADDR_OP = 4'h9;     // chip_operation_control
  localparam logic [10:0] LS_RST = 11'h344;
  localparam logic [10:0] GD_RST = 11'h216;
  localparam logic [10:0] OP_RST = 11'h020;
  localparam logic [10:0] LS_WMASK = 11'h3ff;  // Bit 10 reserved, reads zero
  localparam logic [10:0] OP_STMASK = 11'h7f9; // Sleep and clear are not stored

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LS_TIME_LSB = 8;
  localparam int LS_SINK_LSB = 4;
  localparam int LS_SRC_LSB = 0;
  localparam int GD_PUMP_BIT = 10;
  localparam int GD_FREE_BIT = 9;
  localparam int GD_MODE_LSB = 7;
  localparam int GD_DEAD_LSB = 4;
  localparam int GD_BLANK_LSB = 2;
  localparam int GD_FILT_LSB = 0;
  localparam int OP_THERM_BIT = 10;
  localparam int OP_UV2_BIT = 9;
  localparam int OP_DRV_BIT = 8;
  localparam int OP_CLAMP_BIT = 7;
  localparam int OP_WD_LSB = 5;
  localparam int OP_OCP_BIT = 4;
  localparam int OP_WDEN_BIT = 3;
  localparam int OP_SLEEP_BIT = 2;
  localparam int OP_CLR_BIT = 1;
  localparam int OP_PUV_BIT = 0;

  // ----------------------------------------------------------------
  // Analog set points carried as plain numbers
  // ----------------------------------------------------------------
  localparam int PUMP_FAST_KHZ = 518;
  localparam int PUMP_SLOW_KHZ = 452;
  localparam int PUMP_UV_HI_MV = 4900;
  localparam int PUMP_UV_LO_MV = 4600;
  localparam int SINK_MA[5] = '{20, 60, 500, 1000, 1250};
  localparam int SRC_MA[3] = '{10, 50, 250};

  // ----------------------------------------------------------------
  // Times and their cycle counts
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 20000;
  localparam int TIME_NS[4] = '{220, 440, 880, 1780};
  localparam int DEAD_NS[8] = '{35, 52, 88, 440, 880, 1760, 3520, 5280};
  localparam int SENSE_NS[4] = '{0, 1750, 3500, 7000};
  localparam int WD_MS[4] = '{10, 20, 50, 100};
  localparam int WD_TICK_NS = 1000000;
  localparam int WD_TICK_CYC = WD_TICK_NS / (CLK_PERIOD_PS / 1000);

  // Least time in whole cycles, rounded up; zero stays zero
  function automatic int ns2cyc(input int ns);
    if (ns == 0)
    begin
      return 0;
    end
    return (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction : ns2cyc

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GDC_SIX_IN = 2'b00,
    GDC_THREE_IN = 2'b01,
    GDC_ONE_IN = 2'b10
  } gdc_scheme_t;

  typedef struct packed {
    logic readReq;
    logic [3:0] addr;
    logic [10:0] data;
  } gdc_frame_t;

  typedef struct packed {
    logic [6:0] srcTimeCyc;
    logic [10:0] sinkMa;
    logic [7:0] srcMa;
    logic [9:0] pumpKhz;
    gdc_scheme_t scheme;
    logic freewheelActive;
    logic [8:0] deadCyc;
    logic [8:0] blankCyc;
    logic [8:0] filterCyc;
    logic thermalEn;
    logic ampClamp;
    logic [12:0] pumpUvMv;
  } gdc_cfg_t;

endpackage : gdc_pkg

`default_nettype wire

/* gdc_spi_slave.sv */
// Serial port slave: 16-bit frames, read flag, 4-bit address, 11-bit data.
// Assumes pins synchronous to clk; sclk idles low, data sampled on its fall.
`timescale 1ns/10ps
`default_nettype none

module gdc_spi_slave
  import gdc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic scsN,
  input wire logic sdi,
  output logic sdo,
  output logic sdoOe,
  output logic [3:0] rdAddr,
  input wire logic [10:0] rdData,
  output logic frameValid,
  output gdc_frame_t frame
);

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic sclkPrev_ff;    // Last sampled clock pin
  logic csPrev_ff;      // Last sampled select pin
  logic [15:0] rxShift_ff; // Incoming bits, newest at bit 0
  logic [10:0] txShift_ff; // Outgoing read data
  logic [4:0] bitCnt_ff;   // Saturates at 17 to mark an overlong frame
  logic sdo_ff;
  logic valid_ff;
  gdc_frame_t frame_ff;
  logic sclkRise;
  logic sclkFall;

  assign sclkRise = sclk & ~sclkPrev_ff;
  assign sclkFall = ~sclk & sclkPrev_ff;

  // Pin history
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sclkPrev_ff <= 1'b0;
      csPrev_ff <= 1'b1;
    end
    else
    begin
      sclkPrev_ff <= sclk;
      csPrev_ff <= scsN;
    end
  end

  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst || scsN)
    begin
      bitCnt_ff <= 5'h00;
      rxShift_ff <= 16'h0000;
    end
    else if (sclkFall)
    begin
      rxShift_ff <= {rxShift_ff[14:0], sdi};
      // Saturate so a long frame is never mistaken for a good one
      bitCnt_ff <= (bitCnt_ff == 5'h11) ? bitCnt_ff : bitCnt_ff + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Transmit side: read data goes out after the header
  // ----------------------------------------------------------------
  assign rdAddr = rxShift_ff[3:0];

  always_ff @(posedge clk)
  begin
    if (sys_rst || scsN)
    begin
      txShift_ff <= 11'h000;
      sdo_ff <= 1'b0;
    end
    else if (sclkRise && bitCnt_ff == 5'(HDR_BITS))
    begin
      // Header complete: load the addressed register, first bit out
      txShift_ff <= {rdData[9:0], 1'b0};
      sdo_ff <= rdData[10];
    end
    else if (sclkRise && bitCnt_ff > 5'(HDR_BITS))
    begin
      sdo_ff <= txShift_ff[10];
      txShift_ff <= {txShift_ff[9:0], 1'b0};
    end
  end

  assign sdo = sdo_ff;
  assign sdoOe = ~scsN;

  // ----------------------------------------------------------------
  // Frame hand-off on select release, exactly 16 bits only
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      valid_ff <= 1'b0;
      frame_ff <= '0;
    end
    else
    begin
      valid_ff <= scsN && !csPrev_ff && bitCnt_ff == 5'(FRAME_W);
      if (scsN && !csPrev_ff)
      begin
        frame_ff <= rxShift_ff;
      end
    end
  end

  assign frameValid = valid_ff;
  assign frame = frame_ff;

endmodule : gdc_spi_slave

`default_nettype wire

/* gdc_regs.sv */
// Gate driver control register bank behind the serial port, with watchdog,
// sleep entry, fault clear and decoded configuration for the analog core.
// Assumes raw fault inputs and wake input synchronous to clk at 50 MHz.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Low source time field, four times, resets 3
// - Low sink current field decodes, resets 0x4
// - Low source current field decodes, resets 0x4
// - Pump frequency bit picks centre and spread
// - Freewheel bit, resets one, single-input only
// - Drive scheme: six, three or one input
// - Dead time field, eight times, resets 001
// - Overcurrent blanking field, resets 01
// - Overcurrent deglitch field, resets 10
// - Thermal shutdown polarity depends on grade
// - Bit 9 disables supply undervoltage 2 fault
// - Bit 8 disables gate drive faults
// - Bit 7 enables amplifier output clamp
// - Watchdog timeout field, resets 01
// - Bit 4 disables shunt overcurrent fault
// - Bit 3 enables host watchdog, resets clear
// - Writing one to bit 2 sleeps
// - Writing one to bit 1 clears faults
// - Bit 0 selects pump undervoltage threshold
// - Registers read/write, default on reset, sleep
module gdc_regs
  import gdc_pkg::*;
#(
  parameter int MS_TICK_CYC = WD_TICK_CYC
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic scsN,
  input wire logic sdi,
  output logic sdo,
  output logic sdoOe,
  input wire logic extendedGrade,
  input wire logic wakeReq,
  input wire logic supplyUv2Raw,
  input wire logic driveFaultRaw,
  input wire logic shuntOcpRaw,
  output logic supplyUv2Fault,
  output logic driveFault,
  output logic shuntOcpFault,
  output logic watchdogFault,
  output logic faultClear,
  output logic asleep,
  output gdc_cfg_t cfg
);

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  logic frameValid;      // One-cycle pulse per good frame
  gdc_frame_t frame;     // Captured frame
  logic [3:0] rdAddr;    // Address seen mid-frame
  logic [10:0] rdData;   // Read mux result

  gdc_spi_slave u_spi (
    .clk(clk),
    .sys_rst(sys_rst),
    .sclk(sclk),
    .scsN(scsN),
    .sdi(sdi),
    .sdo(sdo),
    .sdoOe(sdoOe),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .frameValid(frameValid),
    .frame(frame)
  );

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [10:0] ls_ff;        // low_side_drive_strength
  logic [10:0] gd_ff;        // gate_drive_settings
  logic [10:0] op_ff;        // chip_operation_control, stored bits
  logic faultClear_ff;       // Self-clearing clear bit
  logic asleep_ff;           // Device asleep
  logic wrStrobe;            // Write frame accepted
  logic sleepEntry;          // Write asks for sleep

  // Writes are refused while asleep; reads still answer
  assign wrStrobe = frameValid && !frame.readReq && !asleep_ff;
  assign sleepEntry = wrStrobe && frame.addr == ADDR_OP && frame.data[OP_SLEEP_BIT];

  // Register write and defaults; sleep entry wins over the data written
  always_ff @(posedge clk)
  begin
    if (sys_rst || sleepEntry)
    begin
      ls_ff <= LS_RST;
      gd_ff <= GD_RST;
      op_ff <= OP_RST;
    end
    else if (wrStrobe)
    begin
      unique case (frame.addr)
        ADDR_LS:
        begin
          ls_ff <= frame.data & LS_WMASK;
        end
        ADDR_GD:
        begin
          gd_ff <= frame.data;
        end
        ADDR_OP:
        begin
          op_ff <= frame.data & OP_STMASK;
        end
        default:
        begin
          // Unmapped address: write ignored
        end
      endcase
    end
  end

  // Sleep state, left only by the wake input
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      asleep_ff <= 1'b0;
    end
    else if (sleepEntry)
    begin
      asleep_ff <= 1'b1;
    end
    else if (wakeReq)
    begin
      asleep_ff <= 1'b0;
    end
  end

  // Fault clear pulse lasts one cycle, then the bit reads zero again
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      faultClear_ff <= 1'b0;
    end
    else
    begin
      faultClear_ff <= wrStrobe && frame.addr == ADDR_OP && frame.data[OP_CLR_BIT];
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    unique case (rdAddr)
      ADDR_LS:
      begin
        rdData = ls_ff;
      end
      ADDR_GD:
      begin
        rdData = gd_ff;
      end
      ADDR_OP:
      begin
        rdData = op_ff;
        rdData[OP_SLEEP_BIT] = asleep_ff;
        rdData[OP_CLR_BIT] = faultClear_ff;
      end
      default:
      begin
        rdData = 11'h000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  logic [15:0] tickCnt_ff;   // Divider for the 1 ms enable
  logic msTick;              // One-cycle pulse per millisecond
  logic [6:0] wdCnt_ff;      // Milliseconds since last access
  logic [6:0] wdLimit;       // Selected timeout in ms
  logic wdEnable;
  logic wdExpire;
  logic wdFault_ff;

  assign msTick = tickCnt_ff == 16'(MS_TICK_CYC - 1);
  assign wdEnable = op_ff[OP_WDEN_BIT] && !asleep_ff;

  // Millisecond divider runs only while the watchdog is armed
  always_ff @(posedge clk)
  begin
    if (sys_rst || !wdEnable || msTick)
    begin
      tickCnt_ff <= 16'h0000;
    end
    else
    begin
      tickCnt_ff <= tickCnt_ff + 16'h0001;
    end
  end

  // Timeout lookup
  always_comb
  begin
    wdLimit = 7'h00;
    for (int k = 0; k < 4; k++)
    begin
      if (op_ff[OP_WD_LSB +: 2] == 2'(k))
      begin
        wdLimit = 7'(WD_MS[k]);
      end
    end
  end

  assign wdExpire = wdEnable && msTick && wdCnt_ff == wdLimit - 7'h01;

  // Any good frame restarts the count; the host must keep it fed
  always_ff @(posedge clk)
  begin
    if (sys_rst || !wdEnable || frameValid || wdExpire)
    begin
      wdCnt_ff <= 7'h00;
    end
    else if (msTick)
    begin
      wdCnt_ff <= wdCnt_ff + 7'h01;
    end
  end

  // Latched fault; a new expiry beats a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wdFault_ff <= 1'b0;
    end
    else if (wdExpire)
    begin
      wdFault_ff <= 1'b1;
    end
    else if (faultClear_ff)
    begin
      wdFault_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Fault gating toward the protection logic
  // ----------------------------------------------------------------
  logic uv2_ff;
  logic drv_ff;
  logic ocp_ff;

  // Disabled faults neither detect nor report
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      uv2_ff <= 1'b0;
      drv_ff <= 1'b0;
      ocp_ff <= 1'b0;
    end
    else
    begin
      uv2_ff <= supplyUv2Raw && !op_ff[OP_UV2_BIT];
      drv_ff <= driveFaultRaw && !op_ff[OP_DRV_BIT];
      ocp_ff <= shuntOcpRaw && !op_ff[OP_OCP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Configuration decode, registered once for clean outputs
  // ----------------------------------------------------------------
  gdc_cfg_t nxt_cfg;
  gdc_cfg_t cfg_ff;

  always_comb
  begin
    nxt_cfg = '0;
    for (int k = 0; k < 4; k++)
    begin
      if (ls_ff[LS_TIME_LSB +: 2] == 2'(k))
      begin
        nxt_cfg.srcTimeCyc = 7'(ns2cyc(TIME_NS[k]));
      end
      if (gd_ff[GD_BLANK_LSB +: 2] == 2'(k))
      begin
        nxt_cfg.blankCyc = 9'(ns2cyc(SENSE_NS[k]));
      end
      if (gd_ff[GD_FILT_LSB +: 2] == 2'(k))
      begin
        nxt_cfg.filterCyc = 9'(ns2cyc(SENSE_NS[k]));
      end
    end
    for (int k = 0; k < 8; k++)
    begin
      if (gd_ff[GD_DEAD_LSB +: 3] == 3'(k))
      begin
        nxt_cfg.deadCyc = 9'(ns2cyc(DEAD_NS[k]));
      end
    end
    // Sink current: unlisted codes give the 60 mA step
    unique case (ls_ff[LS_SINK_LSB +: 4])
      4'h0: nxt_cfg.sinkMa = 11'(SINK_MA[0]);
      4'h8: nxt_cfg.sinkMa = 11'(SINK_MA[2]);
      4'ha: nxt_cfg.sinkMa = 11'(SINK_MA[3]);
      4'hb: nxt_cfg.sinkMa = 11'(SINK_MA[4]);
      default: nxt_cfg.sinkMa = 11'(SINK_MA[1]);
    endcase
    // Source current: unlisted codes give the 50 mA step
    unique case (ls_ff[LS_SRC_LSB +: 4])
      4'h0: nxt_cfg.srcMa = 8'(SRC_MA[0]);
      4'h8: nxt_cfg.srcMa = 8'(SRC_MA[2]);
      default: nxt_cfg.srcMa = 8'(SRC_MA[1]);
    endcase
    nxt_cfg.pumpKhz = gd_ff[GD_PUMP_BIT] ? 10'(PUMP_SLOW_KHZ) : 10'(PUMP_FAST_KHZ);
    // Code 11 behaves as six independent inputs
    unique case (gd_ff[GD_MODE_LSB +: 2])
      2'b01: nxt_cfg.scheme = GDC_THREE_IN;
      2'b10: nxt_cfg.scheme = GDC_ONE_IN;
      default: nxt_cfg.scheme = GDC_SIX_IN;
    endcase
    nxt_cfg.freewheelActive = gd_ff[GD_FREE_BIT] && gd_ff[GD_MODE_LSB +: 2] == 2'b10;
    // Same bit, opposite sense on the extended grade
    nxt_cfg.thermalEn = extendedGrade ? op_ff[OP_THERM_BIT] : !op_ff[OP_THERM_BIT];
    nxt_cfg.ampClamp = op_ff[OP_CLAMP_BIT];
    nxt_cfg.pumpUvMv = op_ff[OP_PUV_BIT] ? 13'(PUMP_UV_LO_MV) : 13'(PUMP_UV_HI_MV);
  end

  // Configuration register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg_ff <= '0;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfg = cfg_ff;
  assign supplyUv2Fault = uv2_ff;
  assign driveFault = drv_ff;
  assign shuntOcpFault = ocp_ff;
  assign watchdogFault = wdFault_ff;
  assign faultClear = faultClear_ff;
  assign asleep = asleep_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  ls_write_a: assert property (wrStrobe && frame.addr == ADDR_LS && !sleepEntry
    |=> ls_ff == ($past(frame.data) & LS_WMASK)) else $error("low side write lost");
  sleep_default_a: assert property (sleepEntry
    |=> ls_ff == LS_RST && gd_ff == GD_RST && op_ff == OP_RST && asleep_ff)
    else $error("sleep did not restore defaults");
  clear_pulse_a: assert property (wrStrobe && frame.addr == ADDR_OP
    && frame.data[OP_CLR_BIT] |=> faultClear_ff) else $error("clear pulse missing");
  clear_self_a: assert property (faultClear_ff && !wrStrobe
    |=> !faultClear_ff) else $error("clear bit stuck");
  wd_expire_a: assert property (wdExpire |=> wdFault_ff ##1 wdFault_ff)
    else $error("watchdog fault not latched");
  wd_idle_a: assert property (!wdEnable |=> !$rose(wdFault_ff))
    else $error("watchdog fault while disabled");
  freewheel_mode_a: assert property (cfg_ff.freewheelActive
    |-> $past(gd_ff[GD_MODE_LSB +: 2]) == 2'b10) else $error("freewheel outside one-input mode");
  // Decode lags reset by a cycle, so the first edge after release is skipped
  thermal_sense_a: assert property (!$past(sys_rst) |-> cfg_ff.thermalEn ==
    ($past(extendedGrade) ? $past(op_ff[OP_THERM_BIT]) : !$past(op_ff[OP_THERM_BIT])))
    else $error("thermal shutdown sense wrong");
  drive_gate_a: assert property (driveFault |-> !$past(op_ff[OP_DRV_BIT]))
    else $error("gate drive fault reported while disabled");
  dead_reset_a: assert property (!$past(sys_rst) && $past(gd_ff) == GD_RST
    |-> cfg_ff.deadCyc == 9'h003) else $error("default dead time count wrong");

  sleep_c: cover property (sleepEntry ##[1:1000] wakeReq);
  clear_c: cover property (wdFault_ff ##1 faultClear_ff);
  expire_c: cover property (wdExpire);
  read_c: cover property (frameValid && frame.readReq && frame.addr == ADDR_OP);

endmodule : gdc_regs

`default_nettype wire

/* gdc_host_model.sv */
// Host model: serial master that sends frames of up to 16 bits to the register bank.
// Assumes clk is the bank's clock; pins change just after its rising edge.
`timescale 1ns/10ps
`default_nettype none

module gdc_host_model
(
  input wire logic clk,
  input wire logic sdo,
  output logic sclk,
  output logic scsN,
  output logic sdi
);
  // Clocks per serial clock phase; raise it for a slow host
  int phase = 4;

  // Idle pins: clock low, select high
  initial
  begin
    sclk = 1'b0;
    scsN = 1'b1;
    sdi = 1'b0;
  end

  // One frame of n bits, MSB first; read data taken late in each high sclk phase, just before sclk falls
  task automatic xfer(input logic rd, input logic [3:0] a, input logic [10:0] d,
    input int n, output logic [10:0] q);
    logic [15:0] w;
    w = {rd, a, d};
    q = '0;
    @(posedge clk);
    scsN <= 1'b0;
    for (int i = 15; i > 15 - n; i--)
    begin
      @(posedge clk);
      sdi <= w[i];
      sclk <= 1'b1;
      repeat (phase) @(posedge clk);
      // Sampled late in the high phase so the device has settled
      if (i <= 10)
      begin
        q[i] = sdo;
      end
      sclk <= 1'b0;
      repeat (phase - 1) @(posedge clk);
    end
    @(posedge clk);
    scsN <= 1'b1; // Every good frame also kicks the watchdog
    sdi <= ~sdi; // A released data line does not keep its value
    repeat (phase + 2) @(posedge clk);
  endtask : xfer
endmodule : gdc_host_model

`default_nettype wire

/* gdc_regs_test.sv */
// Self-checking bench for the register bank, driven through the host model.
// Assumes MS_TICK_CYC of 10, so a 10 ms watchdog delay is 100 clocks.
`timescale 1ns/10ps
`default_nettype none

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module gdc_regs_test;
  import gdc_pkg::*;
  logic clk, sys_rst, sclk, scsN, sdi, sdo, extendedGrade, wakeReq;
  logic uvRaw, drvRaw, ocpRaw, uvFlt, drvFlt, ocpFlt, wdFlt, faultClear, asleep, sdoOe;
  gdc_cfg_t cfg;
  logic [10:0] rdv;
  int error_cnt = 0;
  int checked = 0;
  int clrSeen = 0;
  logic [3:0] ad [4] = '{ADDR_LS, ADDR_GD, ADDR_OP, 4'h8};
  logic [10:0] dv [4] = '{11'h344, 11'h216, 11'h020, 11'h000};

  // --------------------------------------------------------------
  // Clock, pulse counter and instances
  // --------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Counts clear pulses so a stuck or missing pulse shows
  always @(posedge clk) if (faultClear === 1'b1) clrSeen++;

  gdc_host_model i_host (.clk(clk), .sdo(sdo), .sclk(sclk), .scsN(scsN), .sdi(sdi));

  gdc_regs #(.MS_TICK_CYC(10)) i_dut (.clk(clk), .sys_rst(sys_rst), .sclk(sclk),
    .scsN(scsN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .extendedGrade(extendedGrade),
    .wakeReq(wakeReq), .supplyUv2Raw(uvRaw), .driveFaultRaw(drvRaw),
    .shuntOcpRaw(ocpRaw), .supplyUv2Fault(uvFlt), .driveFault(drvFlt),
    .shuntOcpFault(ocpFlt), .watchdogFault(wdFlt), .faultClear(faultClear),
    .asleep(asleep), .cfg(cfg));

  // --------------------------------------------------------------
  // Access tasks and verdict
  // --------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [10:0] d, input int n = 16);
    i_host.xfer(1'b0, a, d, n, rdv);
  endtask : wr

  task automatic rd(input logic [3:0] a);
    i_host.xfer(1'b1, a, 11'h000, 16, rdv);
  endtask : rd

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    extendedGrade = 1'b0;
    wakeReq = 1'b0;
    uvRaw = 1'b1;
    drvRaw = 1'b1;
    ocpRaw = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    // Decoded defaults
    `CHK("srcTime", 89, cfg.srcTimeCyc)
    `CHK("sinkMa", 60, cfg.sinkMa)
    `CHK("srcMa", 50, cfg.srcMa)
    `CHK("pumpKhz", 518, cfg.pumpKhz)
    `CHK("freewheel", 1'b0, cfg.freewheelActive)
    `CHK("scheme", GDC_SIX_IN, cfg.scheme)
    `CHK("dead", 3, cfg.deadCyc)
    `CHK("blank", 88, cfg.blankCyc)
    `CHK("filter", 175, cfg.filterCyc)
    `CHK("thermal", 1'b1, cfg.thermalEn)
    `CHK("clamp", 1'b0, cfg.ampClamp)
    `CHK("pumpUv", 4900, cfg.pumpUvMv)
    `CHK("uv2", 1'b1, uvFlt)
    `CHK("drv", 1'b1, drvFlt)
    `CHK("ocp", 1'b1, ocpFlt)
    `CHK("oeIdle", 1'b0, sdoOe)
    foreach (ad[i])
    begin
      rd(ad[i]);
      `CHK("readDef", dv[i], rdv)
    end
    // Reserved top bit of the low-side register reads zero
    wr(ADDR_LS, 11'h7ff);
    rd(ADDR_LS);
    `CHK("lsRsvd", 11'h3ff, rdv)
    wr(ADDR_LS, 11'h0b8);
    `CHK("srcTime0", 11, cfg.srcTimeCyc)
    `CHK("sink1250", 1250, cfg.sinkMa)
    `CHK("src250", 250, cfg.srcMa)
    wr(ADDR_GD, 11'h57c);
    `CHK("pump452", 452, cfg.pumpKhz)
    `CHK("oneIn", GDC_ONE_IN, cfg.scheme)
    `CHK("diodeFw", 1'b0, cfg.freewheelActive)
    `CHK("dead7", 264, cfg.deadCyc)
    `CHK("blank3", 350, cfg.blankCyc)
    `CHK("filter0", 0, cfg.filterCyc)
    wr(ADDR_GD, 11'h300);
    `CHK("activeFw", 1'b1, cfg.freewheelActive)
    `CHK("dead0", 2, cfg.deadCyc)
    // A short frame must be ignored
    wr(ADDR_GD, 11'h000, 15);
    rd(ADDR_GD);
    `CHK("shortFrm", 11'h300, rdv)
    // Code 01 is three inputs; code 11 acts as six, so no active freewheel
    wr(ADDR_GD, 11'h080);
    `CHK("threeIn", GDC_THREE_IN, cfg.scheme)
    wr(ADDR_GD, 11'h380);
    `CHK("sixIn11", GDC_SIX_IN, cfg.scheme)
    `CHK("fw11", 1'b0, cfg.freewheelActive)
    // Remaining listed current codes and source times
    wr(ADDR_LS, 11'h1a0);
    `CHK("srcTime1", 22, cfg.srcTimeCyc)
    `CHK("sink1000", 1000, cfg.sinkMa)
    `CHK("src10", 10, cfg.srcMa)
    wr(ADDR_LS, 11'h280);
    `CHK("srcTime2", 44, cfg.srcTimeCyc)
    `CHK("sink500", 500, cfg.sinkMa)
    wr(ADDR_LS, 11'h008);
    `CHK("sink20", 20, cfg.sinkMa)
    wr(ADDR_OP, 11'h781);
    rd(ADDR_OP);
    `CHK("opRead", 11'h781, rdv)
    `CHK("thermOff", 1'b0, cfg.thermalEn)
    extendedGrade <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("thermExt", 1'b1, cfg.thermalEn)
    `CHK("clampOn", 1'b1, cfg.ampClamp)
    `CHK("pump4600", 4600, cfg.pumpUvMv)
    `CHK("uv2Off", 1'b0, uvFlt)
    `CHK("drvOff", 1'b0, drvFlt)
    wr(ADDR_OP, 11'h010);
    `CHK("uv2On", 1'b1, uvFlt)
    `CHK("drvOn", 1'b1, drvFlt)
    `CHK("ocpOff", 1'b0, ocpFlt)
    extendedGrade <= 1'b0;
    // Watchdog with the shortest delay of 100 clocks
    wr(ADDR_OP, 11'h008);
    repeat (80) @(posedge clk);
    `CHK("wdEarly", 1'b0, wdFlt)
    for (int k = 0; k < 60 && wdFlt !== 1'b1; k++) @(posedge clk);
    `CHK("wdFire", 1'b1, wdFlt)
    if (wdFlt !== 1'b1) complete_run();
    clrSeen = 0;
    wr(ADDR_OP, 11'h00a);
    `CHK("clrPulse", 1, clrSeen)
    `CHK("wdClr", 1'b0, wdFlt)
    rd(ADDR_OP);
    `CHK("clrSelf", 11'h008, rdv)
    // Sleep restores defaults and refuses writes until woken
    // Clear too: the watchdog has expired again during the readback
    wr(ADDR_OP, 11'h006);
    `CHK("asleep", 1'b1, asleep)
    rd(ADDR_LS);
    `CHK("sleepDef", 11'h344, rdv)
    wr(ADDR_LS, 11'h000);
    rd(ADDR_LS);
    `CHK("sleepWr", 11'h344, rdv)
    wakeReq <= 1'b1;
    repeat (2) @(posedge clk);
    wakeReq <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("awake", 1'b0, asleep)
    repeat (150) @(posedge clk);
    `CHK("wdOff", 1'b0, wdFlt)
    // Default delay code is 20 ms, 200 clocks
    wr(ADDR_OP, 11'h028);
    repeat (180) @(posedge clk);
    `CHK("wd20Early", 1'b0, wdFlt)
    for (int k = 0; k < 60 && wdFlt !== 1'b1; k++) @(posedge clk);
    `CHK("wd20Fire", 1'b1, wdFlt)
    complete_run();
  end
endmodule : gdc_regs_test

`default_nettype wire
